// ### hdl/epbc_defs.svh
// Purpose: constants for the exception priority and break control block
// Assumes: 8-bit core, 16-bit vector addresses, bus clock only
// Notes:   slot addresses are even; low byte of each vector is at slot+1
`ifndef EPBC_DEFS_SVH
`define EPBC_DEFS_SVH
`define EPBC_NUM_SRC      21
`define EPBC_VEC_RSVD     16'hFFD0
`define EPBC_VEC_SWI      16'hFFFC
`define EPBC_VEC_RESET    16'hFFFE
`define EPBC_SRC_LOW_BYTE 8'hFA
`define EPBC_MASK_RESET   1'h1
`define EPBC_BREAK_FLAG_CLEAR_ENABLE_RESET   1'h0
`define EPBC_IDX_RESET    5'h00
`define EPBC_ALLOW_RESET  1'h1
`endif

// ### hdl/epbc_pkg.sv
// Purpose: types of the exception priority and break control block
// Assumes: nothing beyond the defs header
// Notes:   state codes are written out
package epbc_pkg;
  typedef enum logic [2:0] {
    EPBC_RUN   = 3'h0,
    EPBC_VECHI = 3'h1,
    EPBC_VECLO = 3'h2,
    EPBC_SLEEP = 3'h3
  } epbc_state_type;

  typedef enum logic [1:0] {
    EPBC_KIND_NONE = 2'h0,
    EPBC_KIND_IRQ  = 2'h1,
    EPBC_KIND_SWI  = 2'h2,
    EPBC_KIND_RST  = 2'h3
  } epbc_kind_type;
endpackage

// ### hdl/epbc_arb_if.sv
// Purpose: carries pending requests to the priority encoder and its result
// Assumes: same clock both sides
// Notes:   purely combinational link
`timescale 1ns/100ps
interface epbc_arb_if;
  logic [20:0] req;
  logic        any;
  logic [4:0]  idx;
  modport encoder (input req, output any, output idx);
  modport user    (output req, input any, input idx);
endinterface

// ### hdl/epbc_prio_enc.sv
// Purpose: fixed priority pick among the maskable sources
// Assumes: req[0] is the first source (highest), req[20] the last
// Notes:   result index 0 means first source
`timescale 1ns/100ps
`include "epbc_defs.svh"
module epbc_prio_enc (
  epbc_arb_if.encoder arb
);
  logic [4:0] pick;
  logic       hit;

  always_comb begin
    pick = `EPBC_IDX_RESET;
    hit  = 1'b0;
    // scan low to high priority so the highest wins last
    for (int i = `EPBC_NUM_SRC - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        pick = 5'(i);
        hit  = 1'b1;
      end
    end
  end

  assign arb.any = hit;
  assign arb.idx = pick;
endmodule

// ### hdl/epbc_top.sv
// Purpose: exception arbitration, vector supply, break flag control, low power
// Assumes: core strobes are one-cycle pulses on the bus clock
// Notes:   vector bytes are given on two successive fetch strobes, high first
`timescale 1ns/100ps
`include "epbc_defs.svh"

// Notes on behaviour
// [RQ1] each source owns a two-byte slot; higher address means higher priority
// [RQ2] reset beats everything and is never arbitrated
// [RQ3] break unit request at break point interrupts program flow
// [RQ4] break request sends vector fetch to the software interrupt slot
// [RQ5] a flag clear allow signal goes to every peripheral during break
// [RQ6] enable set lets clears work in break; clear keeps flags set
// [RQ7] debugger register accesses in protected break disturb no set flag
// [RQ8] flag cleared in break with clearing allowed stays cleared afterwards
// [RQ9] two-step clears stay blocked in break even if step one came earlier
// [RQ10] after break the second step clears normally, first step still counts
// [RQ11] wait or stop puts the core into an unclocked low-power state
// [RQ12] wait and stop clear the interrupt mask bit
// [RQ13] a latched interrupt holds until serviced or mask cleared
// [RQ14] at instruction end take hardware interrupt only if unmasked and enabled
// [RQ15] status flag reads one while its source requests, zero otherwise
// [RQ16] vector high byte from even slot address, low byte from odd one
module epbc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_req_i,
  input  wire logic [20:0] src_req_i,
  input  wire logic [20:0] src_en_i,
  input  wire logic        insn_end_i,
  input  wire logic        swi_exec_i,
  input  wire logic        wait_exec_i,
  input  wire logic        stop_exec_i,
  input  wire logic        brk_req_i,
  input  wire logic        brk_exit_i,
  input  wire logic        vec_fetch_i,
  input  wire logic        svc_done_i,
  input  wire logic        mask_set_i,
  input  wire logic        mask_clr_i,
  input  wire logic        break_flag_clear_enable_wr_i,
  input  wire logic        break_flag_clear_enable_i,
  output logic             exc_start_o,
  output logic [15:0]      vec_addr_o,
  output logic [7:0]       vec_byte_o,
  output logic             vec_valid_o,
  output logic             core_clk_hold_o,
  output logic             stop_mode_o,
  output logic             mask_o,
  output logic             brk_state_o,
  output logic             flag_clr_allow_o,
  output logic [20:0]      status_flags_o
);
  typedef struct packed {
    epbc_pkg::epbc_state_type state;
    epbc_pkg::epbc_kind_type  kind;
    logic [4:0]               idx;
    logic                     latched;
    logic                     mask;
    logic                     break_flag_clear_enable;
    logic                     brk;
    logic                     stop;
    logic                     exc_start;
    logic [15:0]              vec_addr;
    logic [7:0]               vec_byte;
    logic                     vec_valid;
    logic [20:0]              flags;
    logic                     hold;
    logic                     allow;
    logic [20:0]              req_s1;
    logic [20:0]              req_s2;
    logic                     brk_s1;
    logic                     brk_s2;
    logic                     rst_s1;
    logic                     rst_s2;
  } epbc_regs_type;

  epbc_regs_type r_ff;
  epbc_regs_type nxt_r;
  logic [20:0]   live;
  logic [15:0]   slot;

  epbc_arb_if arb ();

  epbc_prio_enc u_enc (
    .arb (arb.encoder)
  );

  assign live    = r_ff.req_s2 & src_en_i;                        // see [RQ14]
  assign arb.req = live;

  // slot address: source i at EPBC_SRC_LOW_BYTE minus 2i
  always_comb begin
    unique case (r_ff.kind)
      epbc_pkg::EPBC_KIND_RST:  slot = `EPBC_VEC_RESET;
      epbc_pkg::EPBC_KIND_SWI:  slot = `EPBC_VEC_SWI;            // see [RQ4]
      epbc_pkg::EPBC_KIND_IRQ: begin
        slot = {8'hFF, 8'(`EPBC_SRC_LOW_BYTE - {r_ff.idx, 1'b0})};  // see [RQ1]
      end
      epbc_pkg::EPBC_KIND_NONE: slot = `EPBC_VEC_RSVD;
    endcase
  end

  always_comb begin
    nxt_r           = r_ff;
    nxt_r.exc_start = 1'b0;
    nxt_r.vec_valid = 1'b0;
    // pin and peripheral requests cross into the bus clock first
    nxt_r.req_s1    = src_req_i;
    nxt_r.req_s2    = r_ff.req_s1;
    nxt_r.brk_s1    = brk_req_i;
    nxt_r.brk_s2    = r_ff.brk_s1;
    nxt_r.rst_s1    = reset_req_i;
    nxt_r.rst_s2    = r_ff.rst_s1;
    nxt_r.flags     = r_ff.req_s2;                                // see [RQ15]
    if (break_flag_clear_enable_wr_i) begin
      nxt_r.break_flag_clear_enable = break_flag_clear_enable_i;                                        // see [RQ6]
    end
    if (mask_set_i) begin
      nxt_r.mask = 1'b1;
    end
    if (mask_clr_i) begin
      nxt_r.mask    = 1'b0;
      nxt_r.latched = 1'b0;                                       // see [RQ13]
    end
    if (brk_exit_i) begin
      nxt_r.brk = 1'b0;
    end
    if (svc_done_i) begin
      nxt_r.latched = 1'b0;                                       // see [RQ13]
    end
    unique case (r_ff.state)
      epbc_pkg::EPBC_RUN: begin
        // a held break request is not taken again while in break
        if (r_ff.brk_s2 && !r_ff.brk) begin
          nxt_r.brk       = 1'b1;                                 // see [RQ3]
          nxt_r.kind      = epbc_pkg::EPBC_KIND_SWI;              // see [RQ4]
          nxt_r.exc_start = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECHI;
        end else if (swi_exec_i) begin
          nxt_r.kind      = epbc_pkg::EPBC_KIND_SWI;
          nxt_r.exc_start = 1'b1;
          nxt_r.mask      = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECHI;
        end else if (wait_exec_i || stop_exec_i) begin
          nxt_r.mask  = 1'b0;                                     // see [RQ12]
          nxt_r.stop  = stop_exec_i;
          nxt_r.state = epbc_pkg::EPBC_SLEEP;                     // see [RQ11]
        end else if (insn_end_i && !r_ff.mask && (r_ff.latched || arb.any)) begin
          if (!r_ff.latched) begin
            nxt_r.idx = arb.idx;                                  // see [RQ13]
          end
          nxt_r.latched   = 1'b1;
          nxt_r.kind      = epbc_pkg::EPBC_KIND_IRQ;              // see [RQ14]
          nxt_r.exc_start = 1'b1;
          nxt_r.mask      = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECHI;
        end
      end
      epbc_pkg::EPBC_VECHI: begin
        if (vec_fetch_i) begin
          nxt_r.vec_addr  = slot;                                 // see [RQ16]
          nxt_r.vec_byte  = slot[15:8];
          nxt_r.vec_valid = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECLO;
        end
      end
      epbc_pkg::EPBC_VECLO: begin
        if (vec_fetch_i) begin
          nxt_r.vec_addr  = slot | 16'h0001;                      // see [RQ16]
          nxt_r.vec_byte  = slot[7:0];
          nxt_r.vec_valid = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_RUN;
        end
      end
      epbc_pkg::EPBC_SLEEP: begin
        // any enabled request while the mask is clear, a break or a reset wakes the core
        if (r_ff.brk_s2 && !r_ff.brk) begin
          nxt_r.stop      = 1'b0;
          nxt_r.brk       = 1'b1;
          nxt_r.kind      = epbc_pkg::EPBC_KIND_SWI;
          nxt_r.exc_start = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECHI;
        end else if (arb.any && !r_ff.mask) begin
          nxt_r.stop      = 1'b0;
          nxt_r.latched   = 1'b1;
          nxt_r.idx       = arb.idx;
          nxt_r.kind      = epbc_pkg::EPBC_KIND_IRQ;
          nxt_r.exc_start = 1'b1;
          nxt_r.mask      = 1'b1;
          nxt_r.state     = epbc_pkg::EPBC_VECHI;
        end
      end
    endcase
    // reset overrides any arbitration in progress
    if (r_ff.rst_s2) begin
      nxt_r.kind      = epbc_pkg::EPBC_KIND_RST;                  // see [RQ2]
      nxt_r.exc_start = 1'b1;
      nxt_r.mask      = 1'b1;
      nxt_r.latched   = 1'b0;
      nxt_r.brk       = 1'b0;
      nxt_r.stop      = 1'b0;
      nxt_r.state     = epbc_pkg::EPBC_VECHI;
    end
    // level outputs registered from their next-state sources
    nxt_r.hold  = (nxt_r.state == epbc_pkg::EPBC_SLEEP);          // see [RQ11]
    nxt_r.allow = !nxt_r.brk || nxt_r.break_flag_clear_enable;                       // see [RQ5] see [RQ6]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff       <= '0;
      r_ff.state <= epbc_pkg::EPBC_VECHI;
      r_ff.kind  <= epbc_pkg::EPBC_KIND_RST;
      r_ff.mask  <= `EPBC_MASK_RESET;
      r_ff.break_flag_clear_enable  <= `EPBC_BREAK_FLAG_CLEAR_ENABLE_RESET;
      r_ff.allow <= `EPBC_ALLOW_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // peripherals gate every clear (single or two-step) with this level;
  // a two-step clear keeps its first-step state, so only the final step
  // is blocked, and what is cleared is never restored
  // see [RQ5] see [RQ7] see [RQ8] see [RQ9] see [RQ10]
  assign flag_clr_allow_o = r_ff.allow;

  assign exc_start_o     = r_ff.exc_start;
  assign vec_addr_o      = r_ff.vec_addr;
  assign vec_byte_o      = r_ff.vec_byte;
  assign vec_valid_o     = r_ff.vec_valid;
  assign core_clk_hold_o = r_ff.hold;                             // see [RQ11]
  assign stop_mode_o     = r_ff.stop;
  assign mask_o          = r_ff.mask;
  assign brk_state_o     = r_ff.brk;
  assign status_flags_o  = r_ff.flags;
endmodule

// ### testbench/epbc_checker.sv
// Purpose: checks exception, vector and break outputs
// Assumes: one clock, async active low reset
// Notes:   bound to epbc_top
`timescale 1ns/100ps
module epbc_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [20:0] src_req_i,
  input wire logic        wait_exec_i,
  input wire logic        stop_exec_i,
  input wire logic        brk_req_i,
  input wire logic        vec_fetch_i,
  input wire logic        exc_start_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic [7:0]  vec_byte_o,
  input wire logic        vec_valid_o,
  input wire logic        core_clk_hold_o,
  input wire logic        mask_o,
  input wire logic        brk_state_o,
  input wire logic        flag_clr_allow_o,
  input wire logic [20:0] status_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_vec_cause; vec_valid_o |-> $past(vec_fetch_i); endproperty
  property p_vec_slot; vec_valid_o |-> vec_addr_o >= 16'hFFD0; endproperty
  property p_vec_hi; vec_valid_o && !vec_addr_o[0] |-> vec_byte_o == 8'hFF; endproperty
  property p_vec_lo;
    vec_valid_o && vec_addr_o[0] |-> vec_byte_o == {vec_addr_o[7:1], 1'h0};
  endproperty
  property p_allow; !brk_state_o |-> flag_clr_allow_o; endproperty
  property p_hold_cause;
    $rose(core_clk_hold_o) |-> $past(wait_exec_i) || $past(stop_exec_i);
  endproperty
  property p_hold_unmask; $rose(core_clk_hold_o) |-> !mask_o; endproperty
  property p_entry_mask; exc_start_o && !brk_state_o |-> mask_o; endproperty
  property p_brk_enter; $rose(brk_req_i) |-> ##[1:6] brk_state_o; endproperty
  property p_status; $stable(src_req_i) [*4] |-> status_flags_o == src_req_i; endproperty
  a_vec_cause: // fetch first
    assert property (p_vec_cause) else $error("vector byte without fetch");
  a_vec_slot: // table range
    assert property (p_vec_slot) else $error("vector address below table");
  a_vec_hi: // high byte
    assert property (p_vec_hi) else $error("wrong vector high byte");
  a_vec_lo: // low byte
    assert property (p_vec_lo) else $error("wrong vector low byte");
  a_allow: // outside break
    assert property (p_allow) else $error("flag clear blocked outside break");
  a_hold_cause: // low power
    assert property (p_hold_cause) else $error("core held without wait or stop");
  a_hold_unmask: // mask cleared
    assert property (p_hold_unmask) else $error("mask left set in low power");
  a_entry_mask: // mask set
    assert property (p_entry_mask) else $error("mask not set on entry");
  a_brk_enter: // break entry
    assert property (p_brk_enter) else $error("break request not taken");
  a_status: // flags
    assert property (p_status) else $error("status flags do not follow requests");
  c_irq: cover property (exc_start_o && !brk_state_o);
  c_brk: cover property ($rose(brk_state_o));
  c_hold: cover property ($rose(core_clk_hold_o));
endmodule

bind epbc_top epbc_checker epbc_checker_i (.*);

// ### testbench/epbc_core_model.sv
// Purpose: core model, fetches each vector and releases the latch
// Assumes: vector byte valid the cycle after each fetch pulse
// Notes:   also fetches the reset vector after reset release
`timescale 1ns/100ps
module epbc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       exc_start_i,
  input  wire logic       vec_valid_i,
  input  wire logic [7:0] vec_byte_i,
  output logic            vec_fetch_o,
  output logic            svc_done_o,
  output logic [15:0]     vec_o,
  output int              n_vec_o
);
  logic       boot;
  logic [7:0] hi;
  logic [7:0] lo;
  task automatic fetch(output logic [7:0] b);
    @(negedge clk_i) vec_fetch_o = 1'h1;
    @(negedge clk_i) vec_fetch_o = 1'h0;
    b = (vec_valid_i === 1'h1) ? vec_byte_i : 8'h00;
  endtask
  initial begin
    vec_fetch_o = 1'h0;
    svc_done_o = 1'h0;
    vec_o = 16'h0000;
    n_vec_o = 0;
    boot = 1'h1;
    forever begin
      // look at the design's pulses where they are settled
      @(negedge clk_i);
      if (!rst_n_i) begin
        boot = 1'h1;
      end else if (boot || exc_start_i === 1'h1) begin
        boot = 1'h0;
        fetch(hi);
        fetch(lo);
        vec_o = {hi, lo}; // high first
        @(negedge clk_i) svc_done_o = 1'h1;
        @(negedge clk_i) svc_done_o = 1'h0;
        n_vec_o++;
      end
    end
  end
endmodule

// ### testbench/epbc_top_tb.sv
// Purpose: self-checking bench for the exception and break block
// Assumes: core side played by epbc_core_model
// Notes:   inputs change on the falling clock edge
`timescale 1ns/100ps
module epbc_top_tb;
  logic        clk_i, rst_n_i, reset_req_i, insn_end_i, swi_exec_i, wait_exec_i;
  logic        stop_exec_i, brk_req_i, brk_exit_i, vec_fetch_i, svc_done_i, mask_set_i;
  logic        mask_clr_i, break_flag_clear_enable_wr_i, break_flag_clear_enable_i, exc_start_o, vec_valid_o, core_clk_hold_o;
  logic        stop_mode_o, mask_o, brk_state_o, flag_clr_allow_o;
  logic [20:0] src_req_i, src_en_i, status_flags_o;
  logic [15:0] vec_addr_o, vec;
  logic [7:0]  vec_byte_o;
  int          n_vec, n_mismatch, checked;
  epbc_top epbc_top_i (.*);
  epbc_core_model epbc_core_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .exc_start_i(exc_start_o), .vec_valid_i(vec_valid_o), .vec_byte_i(vec_byte_o),
    .vec_fetch_o(vec_fetch_i), .svc_done_o(svc_done_i), .vec_o(vec), .n_vec_o(n_vec));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i) s = 1'h1;
    @(negedge clk_i) s = 1'h0;
  endtask
  task automatic vec_is(input logic [15:0] exp);
    int n0;
    n0 = n_vec;
    for (int i = 0; i < 60 && n_vec == n0; i++) @(posedge clk_i);
    chk("vectors taken", 21'(n_vec - n0), 21'h000001);
    chk("vector", vec, exp);
  endtask
  task automatic results;
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset;
    vec_is(16'hFFFE);
    chk("last address", vec_addr_o, 16'hFFFF);
    chk("mask", mask_o, 1'h1);
  endtask
  task automatic t_enable;
    int n0;
    @(negedge clk_i) src_en_i = 21'h1FFFFE;
    src_req_i = 21'h000001;
    repeat (4) @(negedge clk_i);
    chk("flags", status_flags_o, 21'h000001);
    n0 = n_vec;
    pulse(mask_clr_i);
    pulse(insn_end_i);
    repeat (4) @(negedge clk_i);
    chk("taken while disabled", 21'(n_vec - n0), 21'h000000);
    chk("mask", mask_o, 1'h0);
    src_en_i = 21'h1FFFFF;
    pulse(insn_end_i);
    vec_is(16'hFFFA);
    @(negedge clk_i) src_req_i = 21'h000000;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic t_swi;
    pulse(mask_clr_i);
    chk("mask", mask_o, 1'h0);
    pulse(mask_set_i);
    chk("mask", mask_o, 1'h1);
    pulse(swi_exec_i);
    vec_is(16'hFFFC);
    chk("break state", brk_state_o, 1'h0);
  endtask
  task automatic t_rst_req;
    pulse(reset_req_i);
    vec_is(16'hFFFE);
    chk("last address", vec_addr_o, 16'hFFFF);
    chk("mask", mask_o, 1'h1);
  endtask
  task automatic t_arb;
    int ks[4] = '{0, 3, 10, 20};
    int n0;
    foreach (ks[j]) begin
      @(negedge clk_i) src_req_i = (21'h000001 << ks[j]) | 21'h100000;
      repeat (4) @(negedge clk_i);
      chk("flags", status_flags_o, src_req_i);
      n0 = n_vec;
      pulse(insn_end_i);
      repeat (4) @(negedge clk_i);
      chk("taken while masked", 21'(n_vec - n0), 21'h000000);
      pulse(mask_clr_i);
      pulse(insn_end_i);
      vec_is(16'hFFFA - 16'(2 * ks[j]));
      chk("mask", mask_o, 1'h1);
      @(negedge clk_i) src_req_i = 21'h000000;
      repeat (4) @(negedge clk_i);
      chk("flags", status_flags_o, 21'h000000);
    end
  endtask
  task automatic t_brk;
    for (int b = 0; b < 2; b++) begin
      @(negedge clk_i) break_flag_clear_enable_i = b[0];
      pulse(break_flag_clear_enable_wr_i);
      brk_req_i = 1'h1;
      vec_is(16'hFFFC);
      chk("break state", brk_state_o, 1'h1);
      chk("clear allow", flag_clr_allow_o, b[0]);
      @(negedge clk_i) brk_req_i = 1'h0;
      repeat (3) @(negedge clk_i);
      pulse(brk_exit_i);
      repeat (2) @(negedge clk_i);
      chk("break state", brk_state_o, 1'h0);
      chk("clear allow", flag_clr_allow_o, 1'h1);
    end
  endtask
  task automatic t_sleep;
    for (int s = 0; s < 2; s++) begin
      if (s == 0) pulse(wait_exec_i);
      else pulse(stop_exec_i);
      chk("core held", core_clk_hold_o, 1'h1);
      chk("stop mode", stop_mode_o, s[0]);
      chk("mask", mask_o, 1'h0);
      src_req_i = 21'h000001;
      vec_is(16'hFFFA);
      chk("core held", core_clk_hold_o, 1'h0);
      @(negedge clk_i) src_req_i = 21'h000000;
      repeat (4) @(negedge clk_i);
    end
  endtask
  initial begin
    {rst_n_i, reset_req_i, insn_end_i, swi_exec_i, wait_exec_i, stop_exec_i} = '0;
    {brk_req_i, brk_exit_i, mask_set_i, mask_clr_i, break_flag_clear_enable_wr_i, break_flag_clear_enable_i} = '0;
    src_req_i = 21'h000000;
    src_en_i = 21'h1FFFFF;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'h1;
    t_reset;
    t_arb;
    t_brk;
    t_sleep;
    t_enable;
    t_swi;
    t_rst_req;
    results;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    results;
  end
endmodule
